// ---- core/fuse_nv_mem.sv ----
// Small register-file model of the non-volatile fuse and lock cells
`timescale 1ns/100ps
module fuse_nv_mem #(
	parameter int WORDS = 8,
	parameter int AW = 3,
	parameter logic [7:0] INIT_LOW = 8'h62,
	parameter logic [7:0] INIT_HIGH = 8'h99,
	parameter logic [7:0] INIT_EXT = 8'hff,
	parameter logic [7:0] INIT_LOCK = 8'hff
) (
	input wire logic clock, // System clock
	input wire logic srst, // Sync reset, active high
	input wire logic wr_en, // Write strobe
	input wire logic [AW-1:0] wr_addr, // Write index
	input wire logic [7:0] wr_data, // Write byte
	input wire logic [AW-1:0] rd_addr, // Read index
	output logic [7:0] rd_data, // Registered read byte
	output logic [7:0] low_live, // Live low fuse cell
	output logic [7:0] high_live, // Live high fuse cell
	output logic [7:0] ext_live, // Live extended fuse cell
	output logic [7:0] lock_live // Live lock cell
);
	logic [7:0] cells_reg [WORDS];

	initial begin
		if (WORDS > (1 << AW) || WORDS < 4)
			$error("fuse_nv_mem: WORDS does not fit AW or is below 4");
	end

	// Reset stands in for the factory-blank state of the cells
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < WORDS; i++)
				cells_reg[i] <= 8'hff;
			cells_reg[0] <= INIT_LOW;
			cells_reg[1] <= INIT_HIGH;
			cells_reg[2] <= INIT_EXT;
			cells_reg[3] <= INIT_LOCK;
		end else if (wr_en) begin
			cells_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clock) begin
		if (srst)
			rd_data <= 8'hff;
		else
			rd_data <= cells_reg[rd_addr];
	end

	assign low_live = cells_reg[0];
	assign high_live = cells_reg[1];
	assign ext_live = cells_reg[2];
	assign lock_live = cells_reg[3];
endmodule

// ---- core/fuse_signature_config_store.sv ----
// Fuse, signature and calibration store behind the parallel programming port
//
// How it works
// R1: Three fuse bytes; programmed bit reads zero
// R2: Extended: top nibble ones, brown-out, test bit
// R3: High bits 7-3: debug, scan, serial, watchdog, preserve
// R4: High bits 2-1 boot size, bit 0 vector
// R5: Serial-programming fuse untouched by serial programming
// R6: Low bit 7 divide by eight, bit 6 clock out
// R7: Low bits 5-4 start-up, 3-0 clock source
// R8: Chip erase keeps fuse values
// R9: First lock bit programmed refuses fuse writes
// R10: Fuses latched on programming entry, applied after exit
// R11: Preserve fuse acts immediately, never latched
// R12: Power-up latches fuses for normal operation
// R13: Three signature bytes readable even when locked
// R14: Calibration byte copied into register at reset
// R15: Action select decides crystal pulse effect
// R16: Write or read strobe runs last command
// R17: Action codes: address, data, command, idle
// R18: Command byte decoding of five commands
// R19: Ready/busy low while programming, high when ready
// R20: Configuration outputs come from latched copies
`timescale 1ns/100ps
module fuse_signature_config_store
	import fuse_store_pkg::*;
#(
	parameter int PROG_BUSY_CYCLES = fuse_store_pkg::PROG_CYCLES,
	parameter logic [7:0] VENDOR_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] MEMORY_SIZE_CODE = 8'h33, // Arbitrary value
	parameter logic [7:0] PART_CODE = 8'h44, // Arbitrary value
	parameter logic [7:0] CALIBRATION_BYTE = 8'h80
) (
	input wire logic clock, // 40 MHz system clock
	input wire logic srst, // Sync reset, active high
	input wire logic prog_mode, // High while in parallel programming mode
	input wire logic serial_prog_access, // High when access comes from serial programming
	input wire fuse_store_pkg::prog_pins_t pins, // Programming port inputs
	output logic [7:0] data_out, // Data bus output
	output logic data_out_en, // Data bus output enable, high drives
	output logic ready_not_busy, // Low while programming
	output fuse_store_pkg::config_t config_out, // Latched fuses to the chip
	output logic eeprom_preserve_on_erase, // Live preserve fuse, active low
	output logic [7:0] oscillator_calibration_register, // Calibration copy
	output logic fuse_write_refused // Last fuse write blocked by lock
);
	import fuse_store_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01,
		ST_DONE = 2'b11
	} prog_state_t;

	prog_state_t state_reg;
	logic [7:0] cmd_reg;
	logic [7:0] addr_reg;
	logic [7:0] data_reg;
	logic [15:0] busy_cnt_reg;
	logic xtal_d_reg, wr_d_reg, oe_d_reg, mode_d_reg;
	logic xtal_rise, wr_fall, oe_fall, mode_rise, mode_fall;
	logic nv_wr_en;
	logic [MEM_AW-1:0] nv_wr_addr, nv_rd_addr;
	logic [7:0] nv_wr_data, nv_rd_data;
	logic [7:0] low_live, high_live, ext_live, lock_live;
	logic fuse_locked;
	logic [1:0] byte_sel;
	logic pending_reg;

	initial begin
		if (PROG_BUSY_CYCLES < 1 || PROG_BUSY_CYCLES > 65535)
			$error("PROG_BUSY_CYCLES out of range");
	end

	function automatic logic is_fuse_sel(input logic [1:0] sel);
		is_fuse_sel = (sel == SEL_LOW) || (sel == SEL_HIGH) || (sel == SEL_EXT);
	endfunction

	function automatic logic [MEM_AW-1:0] sel_to_index(input logic [1:0] sel);
		case (sel)
			SEL_LOW: sel_to_index = NV_LOW;
			SEL_HIGH: sel_to_index = NV_HIGH;
			SEL_EXT: sel_to_index = NV_EXT;
			default: sel_to_index = NV_LOCK;
		endcase
	endfunction

	assign byte_sel = {pins.byte_select_two, pins.byte_select_one};
	assign xtal_rise = pins.crystal_input_strobe && !xtal_d_reg;
	assign wr_fall = !pins.write_n && wr_d_reg;
	assign oe_fall = !pins.output_enable_n && oe_d_reg;
	assign mode_rise = prog_mode && !mode_d_reg;
	assign mode_fall = !prog_mode && mode_d_reg;
	assign fuse_locked = !lock_live[LOCK_FIRST_BIT];

	always_ff @(posedge clock) begin
		if (srst) begin
			xtal_d_reg <= 1'b0;
			wr_d_reg <= 1'b1;
			oe_d_reg <= 1'b1;
			mode_d_reg <= 1'b0;
		end else begin
			xtal_d_reg <= pins.crystal_input_strobe;
			wr_d_reg <= pins.write_n;
			oe_d_reg <= pins.output_enable_n;
			mode_d_reg <= prog_mode;
		end
	end

	// Crystal pulse loads address, data or command
	always_ff @(posedge clock) begin
		if (srst) begin
			cmd_reg <= 8'h00;
			addr_reg <= 8'h00;
			data_reg <= 8'h00;
		end else if (prog_mode && xtal_rise && state_reg == ST_IDLE) begin
			case ({pins.action_select_high, pins.action_select_low}) // see R15
				ACT_LOAD_ADDR: addr_reg <= pins.data_in; // see R17
				ACT_LOAD_DATA: data_reg <= pins.data_in; // see R17
				ACT_LOAD_CMD: cmd_reg <= pins.data_in; // see R17
				default: ; // Idle code: no action
			endcase
		end
	end

	// Write strobe executes the loaded command
	always_comb begin
		nv_wr_en = 1'b0;
		nv_wr_addr = NV_LOW;
		nv_wr_data = data_reg;
		if (prog_mode && wr_fall && state_reg == ST_IDLE) begin
			case (cmd_reg) // see R16 R18
				CMD_WRITE_FUSES: begin
					// Locked device or serial access to serial-enable bit
					if (is_fuse_sel(byte_sel) && !fuse_locked) begin // see R9
						nv_wr_en = 1'b1;
						nv_wr_addr = sel_to_index(byte_sel);
						if (byte_sel == SEL_EXT) // see R2
							nv_wr_data = {4'hf, data_reg[EXT_UNUSED_LSB-1:0]};
						if (byte_sel == SEL_HIGH && serial_prog_access) // see R5
							nv_wr_data[HIGH_SERIAL_PROG_BIT] = high_live[HIGH_SERIAL_PROG_BIT];
					end
				end
				CMD_WRITE_LOCK: begin
					nv_wr_en = 1'b1;
					nv_wr_addr = NV_LOCK;
					nv_wr_data = data_reg & lock_live;
				end
				CMD_CHIP_ERASE: begin
					// Only lock bits return to blank; fuses stay (see R8)
					nv_wr_en = 1'b1;
					nv_wr_addr = NV_LOCK;
					nv_wr_data = ERASED_BYTE;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst)
			fuse_write_refused <= 1'b0;
		else if (prog_mode && wr_fall && state_reg == ST_IDLE && cmd_reg == CMD_WRITE_FUSES)
			fuse_write_refused <= fuse_locked; // see R9
	end

	// Busy sequencing of ready/busy
	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			busy_cnt_reg <= 16'h0000;
		end else begin
			case (state_reg)
				ST_IDLE: if (nv_wr_en) begin
					state_reg <= ST_BUSY;
					busy_cnt_reg <= 16'(PROG_BUSY_CYCLES - 1);
				end
				ST_BUSY: if (busy_cnt_reg == 16'h0000)
					state_reg <= ST_DONE;
				else
					busy_cnt_reg <= busy_cnt_reg - 16'h0001;
				ST_DONE: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst)
			ready_not_busy <= 1'b1;
		else
			ready_not_busy <= !(nv_wr_en || state_reg == ST_BUSY); // see R19
	end

	// Read index selects one of the three fuse bytes or the lock byte
	always_comb begin
		nv_rd_addr = sel_to_index(byte_sel);
	end

	// Read strobe drives the data bus from the selected source
	always_ff @(posedge clock) begin
		if (srst)
			pending_reg <= 1'b0;
		else
			pending_reg <= prog_mode && oe_fall && cmd_reg == CMD_READ_FUSE;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			data_out <= 8'hff;
			data_out_en <= 1'b0;
		end else if (!prog_mode || pins.output_enable_n) begin
			data_out_en <= 1'b0;
		end else if (oe_fall && cmd_reg == CMD_READ_SIG) begin
			data_out_en <= 1'b1;
			if (pins.byte_select_one)
				data_out <= CALIBRATION_BYTE; // see R14
			else begin
				case (addr_reg[1:0]) // see R13
					SIG_ADDR_VENDOR: data_out <= VENDOR_CODE;
					SIG_ADDR_MEMORY_SIZE: data_out <= MEMORY_SIZE_CODE;
					SIG_ADDR_PART: data_out <= PART_CODE;
					default: data_out <= ERASED_BYTE;
				endcase
			end
		end else if (pending_reg) begin
			data_out_en <= 1'b1;
			data_out <= nv_rd_data; // see R1
		end
	end

	// Latched configuration copies
	always_ff @(posedge clock) begin
		if (srst) begin
			config_out <= '1;
		end else if (mode_d_reg == 1'b0 && mode_rise) begin
			config_out <= {ext_live, high_live, low_live}; // see R10
		end else if (mode_fall) begin
			// Leaving programming mode applies what was written during it
			config_out <= {ext_live, high_live, low_live}; // see R10
		end else if (!prog_mode && !mode_fall && config_out == '1 && !mode_d_reg) begin
			config_out <= {ext_live, high_live, low_live}; // see R12 R20
		end
	end

	always_ff @(posedge clock) begin
		if (srst)
			eeprom_preserve_on_erase <= 1'b1;
		else
			eeprom_preserve_on_erase <= high_live[HIGH_EEPROM_SAVE_BIT]; // see R11
	end

	always_ff @(posedge clock) begin
		if (srst)
			oscillator_calibration_register <= CALIBRATION_BYTE; // see R14
	end

	fuse_nv_mem #(
		.WORDS(MEM_WORDS),
		.AW(MEM_AW),
		.INIT_LOW(LOW_FUSE_DEFAULT), // see R6 R7
		.INIT_HIGH(HIGH_FUSE_DEFAULT), // see R3 R4
		.INIT_EXT(EXT_FUSE_DEFAULT), // see R2
		.INIT_LOCK(LOCK_DEFAULT)
	) u_nv (
		.clock(clock),
		.srst(srst),
		.wr_en(nv_wr_en),
		.wr_addr(nv_wr_addr),
		.wr_data(nv_wr_data),
		.rd_addr(nv_rd_addr),
		.rd_data(nv_rd_data),
		.low_live(low_live),
		.high_live(high_live),
		.ext_live(ext_live),
		.lock_live(lock_live)
	);

	property p_lock_refuse;
		@(posedge clock) disable iff (srst)
		(nv_wr_en && fuse_locked) |-> (nv_wr_addr == NV_LOCK);
	endproperty
	a_lock_refuse: assert property (p_lock_refuse) else $error("fuse write while locked"); // see R9

	property p_erase_keeps;
		@(posedge clock) disable iff (srst)
		(nv_wr_en && cmd_reg == CMD_CHIP_ERASE) |=> $stable({ext_live, high_live, low_live});
	endproperty
	a_erase_keeps: assert property (p_erase_keeps) else $error("erase changed fuses"); // see R8

	property p_busy_low;
		@(posedge clock) disable iff (srst)
		nv_wr_en |=> !ready_not_busy [*2];
	endproperty
	a_busy_low: assert property (p_busy_low) else $error("ready not low while busy"); // see R19

	property p_no_apply_in_prog;
		@(posedge clock) disable iff (srst)
		(prog_mode && mode_d_reg) |=> $stable(config_out);
	endproperty
	a_no_apply_in_prog: assert property (p_no_apply_in_prog) else $error("config changed in mode"); // see R10

	property p_preserve_live;
		@(posedge clock) disable iff (srst)
		##1 eeprom_preserve_on_erase == $past(high_live[HIGH_EEPROM_SAVE_BIT]);
	endproperty
	a_preserve_live: assert property (p_preserve_live) else $error("preserve fuse lags"); // see R11

	property p_ext_top;
		@(posedge clock) disable iff (srst)
		ext_live[7:EXT_UNUSED_LSB] == 4'hf;
	endproperty
	a_ext_top: assert property (p_ext_top) else $error("unused extended bits not one"); // see R2

	property p_serial_keep;
		@(posedge clock) disable iff (srst)
		(nv_wr_en && serial_prog_access && nv_wr_addr == NV_HIGH)
			|=> $stable(high_live[HIGH_SERIAL_PROG_BIT]);
	endproperty
	a_serial_keep: assert property (p_serial_keep) else $error("serial bit changed"); // see R5

	property p_cmd_load;
		@(posedge clock) disable iff (srst)
		(prog_mode && xtal_rise && state_reg == ST_IDLE && pins.action_select_high
			&& !pins.action_select_low) |=> cmd_reg == $past(pins.data_in);
	endproperty
	a_cmd_load: assert property (p_cmd_load) else $error("command not loaded"); // see R17
endmodule

// ---- core/fuse_store_pkg.sv ----
// Constants and carrier types for the fuse and signature store
package fuse_store_pkg;
	// Action-select codes sampled on a crystal-input pulse
	localparam logic [1:0] ACT_LOAD_ADDR = 2'b00;
	localparam logic [1:0] ACT_LOAD_DATA = 2'b01;
	localparam logic [1:0] ACT_LOAD_CMD = 2'b10;
	localparam logic [1:0] ACT_IDLE = 2'b11;
	// Command bytes
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_WRITE_FUSES = 8'h40;
	localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
	localparam logic [7:0] CMD_READ_SIG = 8'h08;
	localparam logic [7:0] CMD_READ_FUSE = 8'h04;
	// Signature space addresses
	localparam logic [1:0] SIG_ADDR_VENDOR = 2'h0;
	localparam logic [1:0] SIG_ADDR_MEMORY_SIZE = 2'h1;
	localparam logic [1:0] SIG_ADDR_PART = 2'h2;
	// Fuse byte selectors on the two byte-select pins {bs2, bs1}
	localparam logic [1:0] SEL_LOW = 2'b00;
	localparam logic [1:0] SEL_HIGH = 2'b11;
	localparam logic [1:0] SEL_EXT = 2'b10;
	localparam logic [1:0] SEL_LOCK = 2'b01;
	// Fuse reset (unprogrammed factory) values
	localparam logic [7:0] EXT_FUSE_DEFAULT = 8'hff;
	localparam logic [7:0] HIGH_FUSE_DEFAULT = 8'h99;
	localparam logic [7:0] LOW_FUSE_DEFAULT = 8'h62;
	localparam logic [7:0] LOCK_DEFAULT = 8'hff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// Field positions
	localparam int EXT_UNUSED_LSB = 4;
	localparam int HIGH_SERIAL_PROG_BIT = 5;
	localparam int HIGH_EEPROM_SAVE_BIT = 3;
	localparam int LOCK_FIRST_BIT = 0;
	// Busy time of a fuse, lock or erase operation
	localparam int PROG_TIME_NS = 4500;
	localparam int CLOCK_PERIOD_NS = 25;
	localparam int PROG_CYCLES = (PROG_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int MEM_WORDS = 8;
	localparam int MEM_AW = 3;
	// Indices of the non-volatile bytes in the store
	localparam logic [2:0] NV_LOW = 3'd0;
	localparam logic [2:0] NV_HIGH = 3'd1;
	localparam logic [2:0] NV_EXT = 3'd2;
	localparam logic [2:0] NV_LOCK = 3'd3;
	// Programming port pins, sampled synchronously
	typedef struct packed {
		logic crystal_input_strobe;
		logic action_select_high;
		logic action_select_low;
		logic byte_select_one;
		logic byte_select_two;
		logic write_n;
		logic output_enable_n;
		logic [7:0] data_in;
	} prog_pins_t;
	// Latched configuration handed to the chip
	typedef struct packed {
		logic [7:0] ext_fuses;
		logic [7:0] high_fuses;
		logic [7:0] low_fuses;
	} config_t;
endpackage

// ---- tb/prog_model.sv ----
// Behavioural parallel programmer driving the programming port
`timescale 1ns/100ps
module prog_model
	import fuse_store_pkg::*;
(
	input wire logic clock, // System clock
	output fuse_store_pkg::prog_pins_t pins, // Port pins to the store
	input wire logic [7:0] data_out, // Store bus output
	input wire logic data_out_en, // Store drives the bus
	input wire logic ready_not_busy // Store ready flag
);
	logic xtal = 1'b0, wr_n = 1'b1, oe_n = 1'b1, drv = 1'b1;
	logic [1:0] act = ACT_IDLE, bs = SEL_LOW;
	logic [7:0] dat = 8'h00, last = 8'h00, bus;
	int run = 0, last_busy = 0;
	// A released bus shows the inverse of the last value, never a stale copy
	always_comb begin
		bus = data_out_en ? data_out : (drv ? dat : ~last);
		pins = {xtal, act[1], act[0], bs[0], bs[1], wr_n, oe_n, bus};
	end
	always @(posedge clock) begin
		if (ready_not_busy === 1'b0) begin
			run <= run + 1;
		end else begin
			if (run != 0) last_busy <= run;
			run <= 0;
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic xload(input logic [1:0] a, input logic [7:0] d, input logic [1:0] s);
		act = a;
		dat = d;
		last = d;
		bs = s;
		drv = 1'b1;
		step(1);
		xtal = 1'b1;
		step(2);
		xtal = 1'b0;
		step(1);
	endtask
	// Write strobe, then wait for busy and for ready again, both bounded
	task automatic strobe_write(output logic ok);
		int i;
		wr_n = 1'b0;
		step(2);
		wr_n = 1'b1;
		ok = 1'b0;
		for (i = 0; i < 8 && !ok; i++) begin
			ok = (ready_not_busy === 1'b0);
			if (!ok) step(1);
		end
		for (i = 0; i < 60 && ok && ready_not_busy !== 1'b1; i++) step(1);
		ok = ok && ready_not_busy === 1'b1;
		step(1);
	endtask
	task automatic read_byte(input logic [1:0] s, output logic [7:0] v, output logic en);
		bs = s;
		step(1);
		drv = 1'b0;
		oe_n = 1'b0;
		step(3);
		v = bus;
		en = data_out_en;
		oe_n = 1'b1;
		step(1);
		drv = 1'b1;
	endtask
endmodule

// ---- tb/test_fuse_signature_config_store.sv ----
// Self-checking bench for the fuse and signature store
`timescale 1ns/100ps
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_fuse_signature_config_store;
	import fuse_store_pkg::*;
	localparam int BUSY = 4;
	localparam logic [7:0] VENDOR = 8'h5a; // Arbitrary value
	localparam logic [7:0] MSIZE = 8'h33; // Arbitrary value
	localparam logic [7:0] PART = 8'h44; // Arbitrary value
	localparam logic [7:0] CAL = 8'h80;
	logic clock, srst, prog_mode, serial_prog_access, data_out_en, ready_not_busy;
	logic eeprom_preserve_on_erase, fuse_write_refused, ok, en;
	logic [7:0] data_out, oscillator_calibration_register, v;
	logic [7:0] cells [4];
	logic [7:0] sig [3];
	logic [1:0] sels [6];
	logic [31:0] seed = 32'h33;
	prog_pins_t pins;
	config_t config_out, at_entry;
	int error_cnt = 0, n_checks = 0, cycles = 0;
	fuse_signature_config_store #(.PROG_BUSY_CYCLES(BUSY), .VENDOR_CODE(VENDOR),
		.MEMORY_SIZE_CODE(MSIZE), .PART_CODE(PART), .CALIBRATION_BYTE(CAL)) u_fuse_signature_config_store (
		.clock(clock), .srst(srst), .prog_mode(prog_mode),
		.serial_prog_access(serial_prog_access), .pins(pins), .data_out(data_out),
		.data_out_en(data_out_en), .ready_not_busy(ready_not_busy), .config_out(config_out),
		.eeprom_preserve_on_erase(eeprom_preserve_on_erase),
		.oscillator_calibration_register(oscillator_calibration_register),
		.fuse_write_refused(fuse_write_refused));
	prog_model u_prog_model (.clock(clock), .pins(pins), .data_out(data_out),
		.data_out_en(data_out_en), .ready_not_busy(ready_not_busy));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic run_cmd(input logic [7:0] c, input logic [1:0] s, input logic [7:0] d);
		u_prog_model.xload(ACT_LOAD_CMD, c, s);
		u_prog_model.xload(ACT_LOAD_DATA, d, s);
		u_prog_model.strobe_write(ok);
	endtask
	task automatic rd(input logic [7:0] c, input logic [1:0] s, input logic [7:0] a);
		u_prog_model.xload(ACT_LOAD_CMD, c, s);
		u_prog_model.xload(ACT_LOAD_ADDR, a, s);
		u_prog_model.read_byte(s, v, en);
		`CHECK(en, 1'b1)
	endtask
	task automatic check_fuses();
		for (int s = 0; s < 4; s++) begin
			rd(CMD_READ_FUSE, s[1:0], 8'h00);
			`CHECK(v, cells[s])
		end
	endtask
	initial begin
		srst = 1'b1;
		prog_mode = 1'b0;
		serial_prog_access = 1'b0;
		cells = '{8'h62, 8'hff, 8'hff, 8'h99};
		sig = '{VENDOR, MSIZE, PART};
		sels = '{SEL_LOW, SEL_HIGH, SEL_EXT, SEL_HIGH, SEL_HIGH, SEL_LOW};
		repeat (3) @(posedge clock);
		#1 srst = 1'b0;
		u_prog_model.step(4);
		`CHECK(config_out, {8'hff, 8'h99, 8'h62})
		`CHECK(oscillator_calibration_register, CAL)
		`CHECK(eeprom_preserve_on_erase, 1'b1)
		at_entry = config_out;
		prog_mode = 1'b1;
		u_prog_model.step(3);
		check_fuses();
		for (int a = 0; a < 3; a++) begin
			rd(CMD_READ_SIG, SEL_LOW, a[7:0]);
			`CHECK(v, sig[a])
		end
		rd(CMD_READ_SIG, SEL_LOCK, 8'h00);
		`CHECK(v, CAL)
		for (int k = 0; k < 6; k++) begin
			seed = xorshift(seed);
			v = seed[7:0];
			if (sels[k] == SEL_EXT) v[7] = 1'b0;
			if (k == 3) v[HIGH_EEPROM_SAVE_BIT] = 1'b0;
			serial_prog_access = (k == 4);
			if (k == 4) v[HIGH_SERIAL_PROG_BIT] = ~cells[SEL_HIGH][HIGH_SERIAL_PROG_BIT];
			run_cmd(CMD_WRITE_FUSES, sels[k], v);
			serial_prog_access = 1'b0;
			cells[sels[k]] = v;
			if (sels[k] == SEL_EXT) cells[SEL_EXT] = v | 8'hf0;
			if (k == 4) cells[SEL_HIGH][HIGH_SERIAL_PROG_BIT] = ~v[HIGH_SERIAL_PROG_BIT];
			`CHECK(ok, 1'b1)
			`CHECK(u_prog_model.last_busy, BUSY + 1)
			`CHECK(eeprom_preserve_on_erase, cells[SEL_HIGH][HIGH_EEPROM_SAVE_BIT])
			`CHECK(config_out, at_entry)
		end
		check_fuses();
		u_prog_model.xload(ACT_LOAD_CMD, CMD_READ_FUSE, SEL_LOW);
		u_prog_model.xload(ACT_IDLE, CMD_WRITE_FUSES, SEL_LOW);
		u_prog_model.read_byte(SEL_LOW, v, en);
		`CHECK(v, cells[SEL_LOW])
		prog_mode = 1'b0;
		u_prog_model.step(3);
		`CHECK(config_out, {cells[SEL_EXT], cells[SEL_HIGH], cells[SEL_LOW]})
		prog_mode = 1'b1;
		u_prog_model.step(4);
		`CHECK(config_out, {cells[SEL_EXT], cells[SEL_HIGH], cells[SEL_LOW]})
		run_cmd(CMD_WRITE_LOCK, SEL_LOCK, 8'hfe);
		cells[SEL_LOCK] = 8'hfe;
		run_cmd(CMD_WRITE_FUSES, SEL_LOW, ~cells[SEL_LOW]);
		`CHECK(fuse_write_refused, 1'b1)
		check_fuses();
		rd(CMD_READ_SIG, SEL_LOW, 8'h02);
		`CHECK(v, PART)
		run_cmd(CMD_CHIP_ERASE, SEL_LOW, 8'h00);
		`CHECK(ok, 1'b1)
		cells[SEL_LOCK] = 8'hff;
		check_fuses();
		complete_run();
	end
endmodule
